//--- inc/pldm_consts.svh
// Constants for the link drop and MAC interface configuration bank.
// Assumes a 200 MHz core clock and APB with 32-bit data.
`ifndef PLDM_CONSTS_SVH
`define PLDM_CONSTS_SVH

// Register indexes; the byte address is four times the index.
`define PLDM_IDX_DROP       8'h2d
`define PLDM_IDX_SGMII_TIMER_MIRROR_CONFIG       8'h31
`define PLDM_IDX_MACCTL     8'h32
`define PLDM_IDX_MACCTL2    8'h33

// Link drop configuration fields.
`define PLDM_DROP_EN_BIT    15
`define PLDM_DROP_GIG_BIT   14
`define PLDM_DROP_STS_HI    12
`define PLDM_DROP_STS_LO    8
`define PLDM_DROP_SRC_HI    4
`define PLDM_DROP_SRC_LO    0

// Timer, mirror and reserved fields of the fourth configuration register.
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_RSV_HI    8
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_RSV_LO    7
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_TSEL_HI   6
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_TSEL_LO   5
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_MIR_BIT   0
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_FIX_HI    4
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_FIX_LO    1
`define PLDM_SGMII_TIMER_MIRROR_CONFIG_FIXED     4'b1000

// MAC interface control fields.
`define PLDM_MAC_EN_BIT     7
`define PLDM_MAC_RXT_HI     6
`define PLDM_MAC_RXT_LO     5
`define PLDM_MAC_TXT_HI     4
`define PLDM_MAC_TXT_LO     3
`define PLDM_MAC_TXD_BIT    1
`define PLDM_MAC_RXD_BIT    0
`define PLDM_MAC2_BYP_BIT   4
`define PLDM_MAC2_BDLY_BIT  3
`define PLDM_MAC2_LLAT_BIT  2

// Reset values.
`define PLDM_RST_TSEL       2'b01
`define PLDM_RST_MAC_EN     1'b1
`define PLDM_RST_RXT        2'b10
`define PLDM_RST_TXT        2'b10

// Serial auto-negotiation timer durations and clock rate.
`define PLDM_CLK_MHZ        200
`define PLDM_T11_MS         11
`define PLDM_T800_US        800
`define PLDM_T2_US          2
`define PLDM_T16_MS         16

`endif

//--- inc/pldm_drop_if.sv
// Carrier between the register bank and the drop cause latch.
// Assumes both ends run on the same clock.
interface pldm_drop_if;
  import pldm_pkg::*;

  pldm_cause_t setCause;
  pldm_cause_t clrCause;
  pldm_cause_t cause;

  modport latch (input setCause, input clrCause, output cause);
  modport ctrl  (output setCause, output clrCause, input cause);
endinterface : pldm_drop_if

//--- inc/pldm_pkg.sv
// Types shared by the link drop configuration bank.
// Assumes the constants header is compiled alongside.
package pldm_pkg;

  typedef enum logic [1:0] {
    TSEL_16MS  = 2'b00,
    TSEL_2US   = 2'b01,
    TSEL_800US = 2'b10,
    TSEL_11MS  = 2'b11
  } pldm_tsel_t;

  typedef enum logic {
    TMR_IDLE,
    TMR_RUN
  } pldm_tmr_t;

  typedef logic [4:0] pldm_cause_t;

endpackage : pldm_pkg

//--- sim/pldm_mac_model.sv
// Far side model: link drop detectors, link speed and timer start.
// Assumes the bench calls its tasks from the ref_clk domain.
module pldm_mac_model (
  input  wire logic ref_clk,
  output logic [4:0] dropCriteria,
  output logic       linkIs10or100,
  output logic       serialAnegStart
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dropCriteria = 5'h00;
    linkIs10or100 = 1'b0;
    serialAnegStart = 1'b0;
  end
  task automatic drive(input logic [4:0] v);
    @(posedge ref_clk);
    dropCriteria <= v;
  endtask : drive
  task automatic speed(input logic v);
    @(posedge ref_clk);
    linkIs10or100 <= v;
  endtask : speed
  // Returns at the edge that samples the one-cycle start pulse.
  task automatic pulse;
    @(posedge ref_clk);
    serialAnegStart <= 1'b1;
    @(posedge ref_clk);
    serialAnegStart <= 1'b0;
  endtask : pulse
endmodule : pldm_mac_model

//--- sim/pldm_regs_asserts.sv
// Checker for the link drop and MAC interface register bank.
// Assumes it is bound to pldm_regs and sees only its ports.
module pldm_regs_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [9:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [4:0]  dropCriteria,
  input wire logic        linkIs10or100,
  input wire logic        serialAnegStart,
  input wire logic        fastDropLink,
  input wire logic [4:0]  dropSourceActive,
  input wire logic        serialAnegTimerBusy,
  input wire logic        serialAnegTimerDone,
  input wire logic        portMirrorEnable,
  input wire logic        macIfEnable,
  input wire logic        bypassRxClkDelay,
  input wire logic        lowLatencyPath
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic acc;
  assign acc = psel && penable;

  property p_srcSub;
    (dropSourceActive & ~dropCriteria) == 5'h00;
  endproperty
  a_srcSub: assert property (p_srcSub)
    else $error("drop source active without its criterion");
  property p_link;
    acc && pwrite && paddr == 10'h0b4 && !pwdata[15] |=> !fastDropLink;
  endproperty
  a_link: assert property (p_link)
    else $error("link drop active after the enable was cleared");
  property p_bdly;
    bypassRxClkDelay |-> linkIs10or100;
  endproperty
  a_bdly: assert property (p_bdly)
    else $error("bypass delay outside 10/100 operation");
  property p_llat;
    lowLatencyPath |-> linkIs10or100;
  endproperty
  a_llat: assert property (p_llat)
    else $error("low latency outside 10/100 operation");
  property p_start;
    serialAnegStart |=> serialAnegTimerBusy;
  endproperty
  a_start: assert property (p_start)
    else $error("timer not busy after start");
  property p_done;
    serialAnegTimerDone |-> !serialAnegTimerBusy ##1 !serialAnegTimerDone;
  endproperty
  a_done: assert property (p_done)
    else $error("timer done not a single pulse");
  property p_cfg4Rd;
    acc && !pwrite && paddr == 10'h0c4 |-> prdata[4:1] == 4'b1000;
  endproperty
  a_cfg4Rd: assert property (p_cfg4Rd)
    else $error("fixed timer register bits wrong");
  property p_ctlRd;
    acc && !pwrite && paddr == 10'h0c8 |-> prdata[15:8] == 8'h00;
  endproperty
  a_ctlRd: assert property (p_ctlRd)
    else $error("interface control upper bits not zero");
  property p_mirror;
    acc && pwrite && paddr == 10'h0c4 |=>
      portMirrorEnable == $past(pwdata[0]);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("mirror enable did not follow write");
  property p_macEn;
    acc && pwrite && paddr == 10'h0c8 |=> macIfEnable == $past(pwdata[7]);
  endproperty
  a_macEn: assert property (p_macEn)
    else $error("interface enable did not follow write");

  cover property (serialAnegTimerDone);
  cover property (fastDropLink);
  cover property (acc && !pwrite && paddr == 10'h0b4);
endmodule : pldm_regs_asserts

//--- sim/tb_top.sv
// Self-checking bench for the link drop and MAC interface registers.
// Assumes the far side model drives the detector and speed inputs.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0]  crit, srcAct;
  logic        slow, start, fdl, fdg, busy, done, mir, macEn;
  logic [1:0]  rxThr, txThr;
  logic        txSh, rxSh, byp, bDly, lLat;
  int          fail_count = 0;
  int          samples_checked = 0;

  pldm_regs #(.T11MS_CYC(50), .T800US_CYC(30), .T16MS_CYC(60)) i_pldm_regs (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dropCriteria(crit),
    .linkIs10or100(slow), .serialAnegStart(start), .fastDropLink(fdl),
    .fastDropGigabit(fdg), .dropSourceActive(srcAct),
    .serialAnegTimerBusy(busy), .serialAnegTimerDone(done),
    .portMirrorEnable(mir), .macIfEnable(macEn),
    .rxFifoHalfThreshold(rxThr), .txFifoHalfThreshold(txThr),
    .txClkShifted(txSh), .rxClkShifted(rxSh), .asyncFifoBypass(byp),
    .bypassRxClkDelay(bDly), .lowLatencyPath(lLat));
  pldm_mac_model i_mac (.ref_clk(ref_clk), .dropCriteria(crit),
    .linkIs10or100(slow), .serialAnegStart(start));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic complete_run;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      fail_count++;
      complete_run();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk($sformatf("reg %h", a), r, e);
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
  endtask : wr

  task automatic t_reset;
    rd(10'h0b4, 32'h0);
    rd(10'h0c4, 32'h30);
    rd(10'h0c8, 32'hd0);
    rd(10'h0cc, 32'h0);
  endtask : t_reset
  task automatic t_regs;
    logic [31:0] r;
    logic er;
    wr(10'h0c4, '1);
    wr(10'h0c8, '1);
    wr(10'h0cc, '1);
    wr(10'h0b4, '1);
    #1 chk("outsA", {mir, macEn, rxThr}, 32'hf);
    chk("outsB", {txThr, txSh, rxSh}, 32'hf);
    chk("outsC", {byp, fdg}, 32'h3);
    chk("slow0", {bDly, lLat}, 32'h0);
    i_mac.speed(1'b1);
    #1 chk("slow1", {bDly, lLat}, 32'h3);
    rd(10'h0c4, 32'h1f1);
    rd(10'h0c8, 32'hfb);
    rd(10'h0cc, 32'h1c);
    rd(10'h0b4, 32'hc01f);
    wr(10'h0c8, 32'h0);
    #1 chk("macEn", macEn, 32'h0);
    apb(1'b0, 10'h3fc, 32'h0, r, er);
    chk("slverr", er, 32'h1);
  endtask : t_regs
  task automatic t_drop;
    wr(10'h0b4, 32'h1f);
    i_mac.drive(5'h1f);
    #1 chk("off", fdl, 32'h0);
    i_mac.drive(5'h00);
    rd(10'h0b4, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      wr(10'h0b4, 32'h8000 | (32'h1 << i));
      i_mac.drive(5'h1f);
      #1 chk("src", srcAct, 32'h1 << i);
      i_mac.drive(5'h00);
      rd(10'h0b4, 32'h8000 | (32'h1 << i) | (32'h100 << i));
      rd(10'h0b4, 32'h8000 | (32'h1 << i));
    end
    // A cause still present at the read must survive it.
    i_mac.drive(5'h10);
    rd(10'h0b4, 32'h9010);
    rd(10'h0b4, 32'h9010);
    i_mac.drive(5'h00);
    rd(10'h0b4, 32'h9010);
    rd(10'h0b4, 32'h8010);
  endtask : t_drop
  task automatic t_timer;
    int nTab[4] = '{60, 400, 30, 50};
    int n;
    for (int k = 0; k < 4; k++) begin
      wr(10'h0c4, 32'(k) << 5);
      i_mac.pulse();
      for (n = 1; n < 1000; n++) begin
        @(posedge ref_clk);
        if (done === 1'b1) break;
      end
      chk("timer", 32'(n), 32'(nTab[k]));
    end
  endtask : t_timer

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_regs();
    t_drop();
    t_timer();
    complete_run();
  end
endmodule : tb_top

bind pldm_regs pldm_regs_asserts i_pldm_regs_asserts (
  .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .dropCriteria(dropCriteria), .linkIs10or100(linkIs10or100),
  .serialAnegStart(serialAnegStart), .fastDropLink(fastDropLink),
  .dropSourceActive(dropSourceActive),
  .serialAnegTimerBusy(serialAnegTimerBusy),
  .serialAnegTimerDone(serialAnegTimerDone),
  .portMirrorEnable(portMirrorEnable), .macIfEnable(macIfEnable),
  .bypassRxClkDelay(bypassRxClkDelay), .lowLatencyPath(lowLatencyPath));

//--- verilog/pldm_drop_latch.sv
// Sticky drop cause flags, one per link drop source.
// Assumes a synchronised active-low reset from the register bank.
module pldm_drop_latch
  import pldm_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   rstSync_b,
  pldm_drop_if.latch  drop
);

  pldm_cause_t causeFf_ff;

  // A cause seen in the clearing cycle stays set.
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      causeFf_ff <= '0;
    end else begin
      causeFf_ff <= (causeFf_ff & ~drop.clrCause) | drop.setCause; // [RULE3]
    end
  end

  assign drop.cause = causeFf_ff;

endmodule : pldm_drop_latch

//--- verilog/pldm_regs.sv
// Link drop, serial auto-negotiation timer and MAC interface registers.
// Each register is 16 bits wide and sits in the low half of its APB word.
// Assumes an APB master on ref_clk and link drop detectors that present
// their criteria as levels synchronous to ref_clk.
// Assumes the link speed flag is stable while the MAC datapath uses it.
//
// Our own choice: the APB slave port.
`include "pldm_consts.svh"

// Function
// [RULE1] Global fast drop enable bit turns the fast link drop function on.
// [RULE2] Gigabit bit configures fast drop for 1000BASE-T operation.
// [RULE3] Drop cause status bits latch high when an enabled criterion drops.
// [RULE4] Cause bits 12..8: descrambler sync, rx errors, MLT3, SNR, energy.
// [RULE5] Each of the five drop sources is enabled on its own.
// [RULE6] Source bits 4..0: descrambler sync, rx errors, MLT3, SNR, energy.
// [RULE7] Timer select 11=11ms, 10=800us, 01=2us, 00=16ms, reset 01.
// [RULE8] Reserved bits 4:1 of the timer register ignore writes, read 1000.
// [RULE9] Mirror enable bit turns port mirroring on.
// [RULE10] Interface enable bit, reset one, enables the MAC interface.
// [RULE11] Receive FIFO half-full threshold from bits 6:5, reset 10.
// [RULE12] Transmit FIFO half-full threshold from bits 4:3, reset 10.
// [RULE13] Transmit clock delay bit selects shifted or aligned transmit clock.
// [RULE14] Receive clock delay bit shifts the receive clock against data.
// [RULE15] Bits 15:8 of interface control ignore writes and read zero.
// [RULE16] Bypass bit bypasses the asynchronous FIFO.
// [RULE17] Bypass delay bit delays receive clock at 10 or 100 Mbps.
// [RULE18] Low-latency bit enables the low-latency path at 10 or 100 Mbps.
// [RULE19] A criterion drops the link only if global and source bits set.
// [RULE20] Reading link drop config clears causes not still present.
module pldm_regs
  import pldm_pkg::*;
#(
  parameter int unsigned T11MS_CYC  = `PLDM_T11_MS * 1000 * `PLDM_CLK_MHZ,
  parameter int unsigned T800US_CYC = `PLDM_T800_US * `PLDM_CLK_MHZ,
  parameter int unsigned T16MS_CYC  = `PLDM_T16_MS * 1000 * `PLDM_CLK_MHZ
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  dropCriteria,
  input  wire logic        linkIs10or100,
  input  wire logic        serialAnegStart,
  output logic             fastDropLink,
  output logic             fastDropGigabit,
  output logic [4:0]       dropSourceActive,
  output logic             serialAnegTimerBusy,
  output logic             serialAnegTimerDone,
  output logic             portMirrorEnable,
  output logic             macIfEnable,
  output logic [1:0]       rxFifoHalfThreshold,
  output logic [1:0]       txFifoHalfThreshold,
  output logic             txClkShifted,
  output logic             rxClkShifted,
  output logic             asyncFifoBypass,
  output logic             bypassRxClkDelay,
  output logic             lowLatencyPath
);

  localparam int unsigned T2US_CYC = `PLDM_T2_US * `PLDM_CLK_MHZ;
  localparam int          CW       = 22;

  // Register state.
  logic        rstPipe_ff;
  logic        rstSync_b;
  logic        fastDropEnable_ff;
  logic        fastDropGigabit_ff;
  pldm_cause_t dropSourceEnables_ff;
  logic [1:0]  cfg4Spare_ff;
  pldm_tsel_t  serialAnegTimerSelect_ff;
  logic        mirror_ff;
  logic        macEn_ff;
  logic [1:0]  rxThr_ff;
  logic [1:0]  txThr_ff;
  logic        txDly_ff;
  logic        rxDly_ff;
  logic        bypass_ff;
  logic        bypassDly_ff;
  logic        lowLat_ff;
  logic [31:0] prdata_ff;
  pldm_cause_t readSnap_ff;
  pldm_tmr_t   tmrState_ff;
  logic [CW-1:0] tmrCount_ff;
  logic        tmrDone_ff;

  // Bus decode, read path and timer load.
  logic        setup;
  logic        access;
  logic        wrAccess;
  logic        rdAccess;
  logic        wrDrop;
  logic        wrCfg4;
  logic        wrMac;
  logic        wrMac2;
  logic        rdDrop;
  logic        aligned;
  logic [7:0]  regIdx;
  logic        hitDrop;
  logic        hitCfg4;
  logic        hitMac;
  logic        hitMac2;
  logic        mapped;
  logic [15:0] wdata;
  logic [15:0] nxt_rdword;
  pldm_cause_t causeNow;
  logic [CW-1:0] nxt_tmrLoad;
  logic        tmrDoneHit;

  // Cause flags live in their own module so that set-over-clear priority
  // is decided in one place.
  pldm_drop_if dropBus ();

  pldm_drop_latch u_drop_latch (
    .ref_clk   (ref_clk),
    .rstSync_b (rstSync_b),
    .drop      (dropBus.latch)
  );

  // Reset is taken asynchronously and released through two flip-flops.
  // Only rstSync_b leaves this block; the first stage feeds nothing else.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_ff <= 1'b0;
      rstSync_b  <= 1'b0;
    end else begin
      rstPipe_ff <= 1'b1;
      rstSync_b  <= rstPipe_ff;
    end
  end

  // APB decode; registers sit on aligned words at four times their index.
  // A refused access still ends with no wait state, so the bus never stalls.
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign wrAccess = access & pwrite & ~pslverr;
  assign rdAccess = access & ~pwrite & ~pslverr;
  assign aligned  = (paddr[1:0] == 2'b00);
  assign regIdx   = paddr[9:2];
  assign hitDrop  = aligned & (regIdx == `PLDM_IDX_DROP);
  assign hitCfg4  = aligned & (regIdx == `PLDM_IDX_SGMII_TIMER_MIRROR_CONFIG);
  assign hitMac   = aligned & (regIdx == `PLDM_IDX_MACCTL);
  assign hitMac2  = aligned & (regIdx == `PLDM_IDX_MACCTL2);
  assign mapped   = hitDrop | hitCfg4 | hitMac | hitMac2;
  assign wdata    = pwdata[15:0];
  assign pready   = access;
  assign pslverr  = access & ~mapped;
  assign prdata   = prdata_ff;

  // One strobe per register keeps each storage process to its own decode.
  assign wrDrop   = wrAccess & hitDrop;
  assign wrCfg4   = wrAccess & hitCfg4;
  assign wrMac    = wrAccess & hitMac;
  assign wrMac2   = wrAccess & hitMac2;
  assign rdDrop   = rdAccess & hitDrop;

  // Link drop configuration register.
  // The cause field is read only; writes to it are dropped here.
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      fastDropEnable_ff    <= 1'b0;
      fastDropGigabit_ff   <= 1'b0;
      dropSourceEnables_ff <= '0;
    end else if (wrDrop) begin
      fastDropEnable_ff    <= wdata[`PLDM_DROP_EN_BIT]; // [RULE1]
      fastDropGigabit_ff   <= wdata[`PLDM_DROP_GIG_BIT]; // [RULE2]
      dropSourceEnables_ff <=
        wdata[`PLDM_DROP_SRC_HI:`PLDM_DROP_SRC_LO]; // [RULE5]
    end
  end

  // Fourth configuration register; bits 4:1 hold no storage.
  // Bits 8:7 are spare storage that reads back as written.
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      cfg4Spare_ff             <= 2'b00;
      serialAnegTimerSelect_ff <= pldm_tsel_t'(`PLDM_RST_TSEL);
      mirror_ff                <= 1'b0;
    end else if (wrCfg4) begin
      cfg4Spare_ff <= wdata[`PLDM_SGMII_TIMER_MIRROR_CONFIG_RSV_HI:`PLDM_SGMII_TIMER_MIRROR_CONFIG_RSV_LO];
      serialAnegTimerSelect_ff <=
        pldm_tsel_t'(wdata[`PLDM_SGMII_TIMER_MIRROR_CONFIG_TSEL_HI:`PLDM_SGMII_TIMER_MIRROR_CONFIG_TSEL_LO]); // [RULE7]
      mirror_ff <= wdata[`PLDM_SGMII_TIMER_MIRROR_CONFIG_MIR_BIT]; // [RULE9]
    end
  end

  // MAC interface control register; upper byte and bit 2 are not stored.
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      macEn_ff <= `PLDM_RST_MAC_EN;
      rxThr_ff <= `PLDM_RST_RXT;
      txThr_ff <= `PLDM_RST_TXT;
      txDly_ff <= 1'b0;
      rxDly_ff <= 1'b0;
    end else if (wrMac) begin
      macEn_ff <= wdata[`PLDM_MAC_EN_BIT]; // [RULE10]
      rxThr_ff <= wdata[`PLDM_MAC_RXT_HI:`PLDM_MAC_RXT_LO]; // [RULE11]
      txThr_ff <= wdata[`PLDM_MAC_TXT_HI:`PLDM_MAC_TXT_LO]; // [RULE12]
      txDly_ff <= wdata[`PLDM_MAC_TXD_BIT]; // [RULE13]
      rxDly_ff <= wdata[`PLDM_MAC_RXD_BIT]; // [RULE14]
    end
  end

  // Second MAC interface control register.
  // Bits 15:5 and 1:0 hold no storage and read zero.
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      bypass_ff    <= 1'b0;
      bypassDly_ff <= 1'b0;
      lowLat_ff    <= 1'b0;
    end else if (wrMac2) begin
      bypass_ff    <= wdata[`PLDM_MAC2_BYP_BIT]; // [RULE16]
      bypassDly_ff <= wdata[`PLDM_MAC2_BDLY_BIT]; // [RULE17]
      lowLat_ff    <= wdata[`PLDM_MAC2_LLAT_BIT]; // [RULE18]
    end
  end

  // A criterion counts only with the global and its own source bit set.
  // A disabled source therefore reaches neither the latch nor the link.
  assign causeNow = dropCriteria & dropSourceEnables_ff
                    & {5{fastDropEnable_ff}}; // [RULE19]

  // Cause bits keep the source order of the enable field.
  assign dropBus.setCause = causeNow; // [RULE3] [RULE4] [RULE6]

  // Only cause bits that were shown to software are cleared. A cause that
  // arrives between the setup and access cycles survives for the next read.
  assign dropBus.clrCause = rdDrop ?
                            (readSnap_ff & ~causeNow) : '0; // [RULE20]

  // Read word assembly.
  // Unmapped indexes and reserved bits read as zero, save bits 4:1 of the timer register, which read 1000, and its bits 8:7, which read as written.
  always_comb begin
    nxt_rdword = 16'h0000;
    if (hitDrop) begin
      nxt_rdword[`PLDM_DROP_EN_BIT]  = fastDropEnable_ff;
      nxt_rdword[`PLDM_DROP_GIG_BIT] = fastDropGigabit_ff;
      nxt_rdword[`PLDM_DROP_STS_HI:`PLDM_DROP_STS_LO] = dropBus.cause;
      nxt_rdword[`PLDM_DROP_SRC_HI:`PLDM_DROP_SRC_LO] = dropSourceEnables_ff;
    end else if (hitCfg4) begin
      nxt_rdword[`PLDM_SGMII_TIMER_MIRROR_CONFIG_RSV_HI:`PLDM_SGMII_TIMER_MIRROR_CONFIG_RSV_LO] = cfg4Spare_ff;
      nxt_rdword[`PLDM_SGMII_TIMER_MIRROR_CONFIG_TSEL_HI:`PLDM_SGMII_TIMER_MIRROR_CONFIG_TSEL_LO] =
        serialAnegTimerSelect_ff;
      nxt_rdword[`PLDM_SGMII_TIMER_MIRROR_CONFIG_FIX_HI:`PLDM_SGMII_TIMER_MIRROR_CONFIG_FIX_LO] =
        `PLDM_SGMII_TIMER_MIRROR_CONFIG_FIXED; // [RULE8]
      nxt_rdword[`PLDM_SGMII_TIMER_MIRROR_CONFIG_MIR_BIT] = mirror_ff;
    end else if (hitMac) begin
      nxt_rdword[`PLDM_MAC_EN_BIT] = macEn_ff;
      nxt_rdword[`PLDM_MAC_RXT_HI:`PLDM_MAC_RXT_LO] = rxThr_ff;
      nxt_rdword[`PLDM_MAC_TXT_HI:`PLDM_MAC_TXT_LO] = txThr_ff;
      nxt_rdword[`PLDM_MAC_TXD_BIT] = txDly_ff;
      nxt_rdword[`PLDM_MAC_RXD_BIT] = rxDly_ff; // [RULE15]
    end else if (hitMac2) begin
      nxt_rdword[`PLDM_MAC2_BYP_BIT]  = bypass_ff;
      nxt_rdword[`PLDM_MAC2_BDLY_BIT] = bypassDly_ff;
      nxt_rdword[`PLDM_MAC2_LLAT_BIT] = lowLat_ff;
    end
  end

  // Read data is captured in the setup cycle and held through access.
  // The snapshot taken with it is what the clearing logic trusts.
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      prdata_ff   <= 32'h0000_0000;
      readSnap_ff <= '0;
    end else if (setup && !pwrite) begin
      prdata_ff   <= {16'h0000, nxt_rdword};
      readSnap_ff <= hitDrop ? dropBus.cause : '0;
    end
  end

  // Timer length chosen by the select field at the start pulse.
  // The 2 us count follows from the clock rate; the longer counts are
  // parameters so that a bench can shorten them.
  always_comb begin
    nxt_tmrLoad = CW'(T2US_CYC);
    unique case (serialAnegTimerSelect_ff)
      TSEL_11MS:  nxt_tmrLoad = CW'(T11MS_CYC);
      TSEL_800US: nxt_tmrLoad = CW'(T800US_CYC);
      TSEL_2US:   nxt_tmrLoad = CW'(T2US_CYC);
      TSEL_16MS:  nxt_tmrLoad = CW'(T16MS_CYC);
    endcase
  end

  // A start while busy restarts the count with the newly selected length.
  // The count reaches zero on the edge that raises done, and then idles.
  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      tmrState_ff <= TMR_IDLE;
      tmrCount_ff <= '0;
    end else begin
      if (serialAnegStart) begin
        tmrState_ff <= TMR_RUN;
        tmrCount_ff <= nxt_tmrLoad - CW'(1); // [RULE7]
      end else begin
        unique case (tmrState_ff)
          TMR_IDLE: begin
            tmrCount_ff <= '0;
          end
          TMR_RUN: begin
            if (tmrCount_ff == CW'(1)) begin
              tmrState_ff <= TMR_IDLE;
            end
            tmrCount_ff <= tmrCount_ff - CW'(1);
          end
        endcase
      end
    end
  end

  // Done pulses exactly the selected count of cycles after the start.
  assign tmrDoneHit = !serialAnegStart && (tmrState_ff == TMR_RUN)
                      && (tmrCount_ff == CW'(1));

  always_ff @(posedge ref_clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      tmrDone_ff <= 1'b0;
    end else begin
      tmrDone_ff <= tmrDoneHit; // [RULE7]
    end
  end

  // Control outputs; the speed-dependent ones are gated here so that a
  // gigabit link never sees them.
  assign fastDropLink        = |causeNow; // [RULE1] [RULE19]
  assign fastDropGigabit     = fastDropEnable_ff & fastDropGigabit_ff; // [RULE2]
  assign dropSourceActive    = causeNow;
  assign serialAnegTimerBusy = (tmrState_ff == TMR_RUN);
  assign serialAnegTimerDone = tmrDone_ff;
  assign portMirrorEnable    = mirror_ff; // [RULE9]
  assign macIfEnable         = macEn_ff; // [RULE10]
  assign rxFifoHalfThreshold = rxThr_ff;
  assign txFifoHalfThreshold = txThr_ff;
  assign txClkShifted        = txDly_ff;
  assign rxClkShifted        = rxDly_ff;
  assign asyncFifoBypass     = bypass_ff; // [RULE16]
  assign bypassRxClkDelay    = bypassDly_ff & linkIs10or100; // [RULE17]
  assign lowLatencyPath      = lowLat_ff & linkIs10or100; // [RULE18]

endmodule : pldm_regs
